// >>> rtl/sktd_pkg.sv
`default_nettype none

package sktd_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_SKCNT = 8'h0C;
	localparam logic [1:0] MEM_PAGE = 2'h1;
	localparam int unsigned MEM_DEPTH = 16;
	localparam int unsigned MEM_AW = 4;

	// ****************************************
	// field layout
	// ****************************************
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_BIT_LSB = 4;
	localparam int unsigned CMD_ADR_LSB = 8;
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_AC = 1;
	localparam int unsigned FLG_Z = 2;
	localparam int unsigned FLG_OV = 3;
	localparam int unsigned FLG_SC = 4;
	localparam int unsigned FLG_CZ = 5;
	localparam int unsigned FLG_W = 6;
	localparam int unsigned STAT_BUSY = 8;
	localparam int unsigned STAT_SKIP = 9;
	localparam logic [2:0] OP_LAST = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [2:0] {
		OP_INC_MEM_SKIP_ZERO,
		OP_INC_TO_ACC_SKIP_ZERO,
		OP_SKIP_IF_BIT_SET,
		OP_SKIP_IF_NONZERO,
		OP_SUBTRACT_TO_ACC,
		OP_SUBTRACT_TO_MEM
	} sktd_op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TAIL} sktd_state_t;

	typedef enum logic [2:0] {K_CMD, K_ACC, K_STAT, K_SKCNT, K_MEM, K_NONE} sktd_kind_t;

endpackage

`default_nettype wire

// >>> rtl/sktd_core.sv
// Operation
// - increment-to-memory: byte plus one written back, skip when zero, flags kept
// - increment-to-accumulator: byte plus one into acc, memory kept, skip when zero
// - skip instructions take two cycles; dummy slot inserted when skipping
// - bit test: skip when selected bit is one, nothing else changes
// - nonzero test: byte rewritten unchanged, skip when nonzero, flags kept
// - subtract-to-acc: acc minus byte into acc, memory kept
// - subtract-to-memory: acc minus byte written into that byte
// - subtract carry: zero on borrow, one when result zero or positive
// - subtract updates overflow, zero, aux carry, carry, signed compare, combined zero
`timescale 1ns/1ps
`default_nettype none

module sktd_core
	import sktd_pkg::*;
(
	input  wire logic              aclk,          // core clock, 10 MHz
	input  wire logic              aresetn,       // synchronous reset, low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
	input  wire logic              s_axi_awvalid, // write address valid
	output logic                   s_axi_awready, // write address ready
	input  wire logic [31:0]       s_axi_wdata,   // write data
	input  wire logic [3:0]        s_axi_wstrb,   // write strobes
	input  wire logic              s_axi_wvalid,  // write data valid
	output logic                   s_axi_wready,  // write data ready
	output logic [1:0]             s_axi_bresp,   // write response
	output logic                   s_axi_bvalid,  // write response valid
	input  wire logic              s_axi_bready,  // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
	input  wire logic              s_axi_arvalid, // read address valid
	output logic                   s_axi_arready, // read address ready
	output logic [31:0]            s_axi_rdata,   // read data
	output logic [1:0]             s_axi_rresp,   // read response
	output logic                   s_axi_rvalid,  // read data valid
	input  wire logic              s_axi_rready,  // read data ready
	output logic                   dummy_slot     // high during an inserted dummy cycle
);

	typedef struct packed {
		logic                            awhave;
		logic [ADDR_W-1:0]               awaddr;
		logic                            whave;
		logic [31:0]                     wdata;
		logic [3:0]                      wstrb;
		logic                            awready;
		logic                            wready;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic                            arready;
		logic                            rvalid;
		logic [1:0]                      rresp;
		logic [31:0]                     rdata;
		sktd_state_t                     state;
		sktd_op_t                        op;
		logic [MEM_AW-1:0]               addr;
		logic [2:0]                      bsel;
		logic                            skip;
		logic                            dummy;
		logic [7:0]                      skcnt;
		logic [7:0]                      acc;
		logic [FLG_W-1:0]                flags;
		logic [MEM_DEPTH-1:0][7:0]       mem;
	} sktd_regs_t;

	sktd_regs_t st_reg;
	sktd_regs_t st_next;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic sktd_kind_t reg_kind(input logic [ADDR_W-1:0] a);
		if (a[7:6] == MEM_PAGE)
			return K_MEM;
		else if (a == ADDR_CMD)
			return K_CMD;
		else if (a == ADDR_ACC)
			return K_ACC;
		else if (a == ADDR_STAT)
			return K_STAT;
		else if (a == ADDR_SKCNT)
			return K_SKCNT;
		return K_NONE;
	endfunction

	function automatic logic is_skip_op(input sktd_op_t o);
		return (o != OP_SUBTRACT_TO_ACC) && (o != OP_SUBTRACT_TO_MEM);
	endfunction

	function automatic logic [FLG_W-1:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
		logic [8:0]       d;
		logic [4:0]       dl;
		logic [FLG_W-1:0] f;
		d = {1'b0, a} - {1'b0, b};
		dl = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		f = '0;
		f[FLG_C] = ~d[8];
		f[FLG_AC] = ~dl[4];
		f[FLG_Z] = (d[7:0] == BYTE_ZERO);
		f[FLG_OV] = (a[7] ^ b[7]) & (d[7] ^ a[7]);
		f[FLG_SC] = f[FLG_OV] ^ d[7];
		f[FLG_CZ] = f[FLG_Z];
		return f;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	logic [7:0]  opnd;
	logic [7:0]  inc;
	logic [7:0]  diff;
	logic        busy;
	logic [31:0] rd;
	sktd_kind_t  wk;

	always_comb
	begin
		opnd = st_reg.mem[st_reg.addr];
		inc = opnd + BYTE_ONE;
		diff = st_reg.acc - opnd;
		busy = (st_reg.state != ST_IDLE);
		rd = '0;
		wk = reg_kind(st_reg.awaddr);
		st_next = st_reg;
		st_next.dummy = 1'b0;

		unique case (st_reg.state)
			ST_IDLE:
			begin
			end
			ST_EXEC:
			begin
				st_next.skip = 1'b0;
				unique case (st_reg.op)
					OP_INC_MEM_SKIP_ZERO:
					begin
						st_next.mem[st_reg.addr] = inc;
						st_next.skip = (inc == BYTE_ZERO);
					end
					OP_INC_TO_ACC_SKIP_ZERO:
					begin
						st_next.acc = inc;
						st_next.skip = (inc == BYTE_ZERO);
					end
					OP_SKIP_IF_BIT_SET:
						st_next.skip = opnd[st_reg.bsel];
					OP_SKIP_IF_NONZERO:
					begin
						st_next.mem[st_reg.addr] = opnd;
						st_next.skip = (opnd != BYTE_ZERO);
					end
					OP_SUBTRACT_TO_ACC:
					begin
						st_next.acc = diff;
						st_next.flags = sub_flags(st_reg.acc, opnd);
					end
					OP_SUBTRACT_TO_MEM:
					begin
						st_next.mem[st_reg.addr] = diff;
						st_next.flags = sub_flags(st_reg.acc, opnd);
					end
				endcase
				// skip class always spends a second cycle; it is the dummy slot if skipping
				st_next.state = is_skip_op(st_reg.op) ? ST_TAIL : ST_IDLE;
				st_next.dummy = is_skip_op(st_reg.op) & st_next.skip;
				if (is_skip_op(st_reg.op) && st_next.skip)
					st_next.skcnt = st_reg.skcnt + BYTE_ONE;
			end
			ST_TAIL:
				st_next.state = ST_IDLE;
		endcase

		// ****************************************
		// axi write channel
		// ****************************************
		if (st_reg.awready && s_axi_awvalid)
		begin
			st_next.awhave = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (st_reg.wready && s_axi_wvalid)
		begin
			st_next.whave = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;
		if (st_reg.awhave && st_reg.whave && !st_reg.bvalid)
		begin
			st_next.awhave = 1'b0;
			st_next.whave = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = (wk == K_NONE) ? RESP_SLVERR : RESP_OKAY;
			// writes during execution are dropped so operands cannot change mid-instruction
			if (st_reg.wstrb[0] && !busy)
			begin
				unique case (wk)
					K_CMD:
						if (st_reg.wdata[CMD_OP_LSB +: 3] <= OP_LAST)
						begin
							st_next.op = sktd_op_t'(st_reg.wdata[CMD_OP_LSB +: 3]);
							st_next.bsel = st_reg.wdata[CMD_BIT_LSB +: 3];
							st_next.addr = st_reg.wdata[CMD_ADR_LSB +: MEM_AW];
							st_next.state = ST_EXEC;
						end
					K_ACC:
						st_next.acc = st_reg.wdata[7:0];
					K_STAT:
						st_next.flags = st_reg.wdata[FLG_W-1:0];
					K_MEM:
						st_next.mem[st_reg.awaddr[MEM_AW+1:2]] = st_reg.wdata[7:0];
					default:
					begin
					end
				endcase
			end
		end

		// ****************************************
		// axi read channel
		// ****************************************
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (st_reg.arready && s_axi_arvalid)
		begin
			unique case (reg_kind(s_axi_araddr))
				K_CMD:
				begin
					rd[CMD_OP_LSB +: 3] = st_reg.op;
					rd[CMD_BIT_LSB +: 3] = st_reg.bsel;
					rd[CMD_ADR_LSB +: MEM_AW] = st_reg.addr;
				end
				K_ACC:
					rd[7:0] = st_reg.acc;
				K_STAT:
				begin
					rd[FLG_W-1:0] = st_reg.flags;
					rd[STAT_BUSY] = busy;
					rd[STAT_SKIP] = st_reg.skip;
				end
				K_SKCNT:
					rd[7:0] = st_reg.skcnt;
				K_MEM:
					rd[7:0] = st_reg.mem[s_axi_araddr[MEM_AW+1:2]];
				default:
				begin
				end
			endcase
			st_next.rvalid = 1'b1;
			st_next.rdata = rd;
			st_next.rresp = (reg_kind(s_axi_araddr) == K_NONE) ? RESP_SLVERR : RESP_OKAY;
		end

		st_next.awready = !st_next.awhave && !st_next.bvalid;
		st_next.wready = !st_next.whave && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rdata = st_reg.rdata;
	assign dummy_slot = st_reg.dummy;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic ex;
	assign ex = (st_reg.state == ST_EXEC);

	inc_mem_wrap_a: assert property (ex && st_reg.op == OP_INC_MEM_SKIP_ZERO |=>
		st_reg.mem[$past(st_reg.addr)] == 8'($past(opnd) + BYTE_ONE)
		&& st_reg.skip == ($past(opnd) == 8'hFF) && $stable(st_reg.flags))
		else $error("increment to memory wrong");
	inc_acc_a: assert property (ex && st_reg.op == OP_INC_TO_ACC_SKIP_ZERO |=>
		st_reg.acc == 8'($past(opnd) + BYTE_ONE) && $stable(st_reg.mem) && $stable(st_reg.flags))
		else $error("increment to accumulator wrong");
	skip_timing_a: assert property (ex && is_skip_op(st_reg.op) |=>
		st_reg.state == ST_TAIL && dummy_slot == st_reg.skip ##1 st_reg.state == ST_IDLE && !dummy_slot)
		else $error("skip cycle timing wrong");
	bit_test_a: assert property (ex && st_reg.op == OP_SKIP_IF_BIT_SET |=>
		st_reg.skip == $past(opnd[st_reg.bsel]) && $stable(st_reg.mem) && $stable(st_reg.acc))
		else $error("bit test skip wrong");
	nz_skip_a: assert property (ex && st_reg.op == OP_SKIP_IF_NONZERO |=>
		st_reg.skip == ($past(opnd) != BYTE_ZERO) && $stable(st_reg.mem) && $stable(st_reg.flags))
		else $error("nonzero skip wrong");
	sub_acc_a: assert property (ex && st_reg.op == OP_SUBTRACT_TO_ACC |=>
		st_reg.acc == 8'($past(st_reg.acc) - $past(opnd)) && $stable(st_reg.mem) && st_reg.state == ST_IDLE)
		else $error("subtract to accumulator wrong");
	sub_mem_a: assert property (ex && st_reg.op == OP_SUBTRACT_TO_MEM |=>
		st_reg.mem[$past(st_reg.addr)] == 8'($past(st_reg.acc) - $past(opnd)) && $stable(st_reg.acc))
		else $error("subtract to memory wrong");
	sub_carry_a: assert property (ex && !is_skip_op(st_reg.op) |=>
		st_reg.flags[FLG_C] == ($past(st_reg.acc) >= $past(opnd)))
		else $error("subtract carry wrong");
	sub_zero_a: assert property (ex && !is_skip_op(st_reg.op) |=>
		st_reg.flags[FLG_Z] == ($past(st_reg.acc) == $past(opnd)) && st_reg.flags[FLG_CZ] == st_reg.flags[FLG_Z])
		else $error("subtract zero flags wrong");

endmodule

`default_nettype wire

// >>> dv/sktd_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
	import sktd_pkg::*;
;
	typedef struct packed {logic [7:0] acc; logic [7:0] mem; logic [5:0] fl; logic sk;} sktd_exp_t;

	logic              aclk;
	logic              aresetn;
	logic [ADDR_W-1:0] awaddr;
	logic [ADDR_W-1:0] araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, dummy_slot;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	int                errors = 0;
	int                n_compared = 0;
	int                n_dummy = 0;

	sktd_core u_sktd_core (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.dummy_slot(dummy_slot)
	);

	initial
	begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end

	// counts inserted dummy cycles seen at the pin
	always @(posedge aclk)
		if (aresetn === 1'h1 && dummy_slot === 1'h1)
			n_dummy++;

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// register bus master
	// ****************************************
	// first edge lets the last release land, so no signal is set twice in one step
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1);
		rs = bresp;
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1);
		dt = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask

	// ****************************************
	// reference behaviour
	// ****************************************
	function automatic sktd_exp_t model(logic [2:0] op, logic [2:0] b, logic [7:0] a, logic [7:0] m,
		logic [5:0] f);
		sktd_exp_t e;
		logic [7:0] r;
		logic       ov;
		e = '{a, m, f, 1'h0};
		r = a - m;
		ov = (a[7] ^ m[7]) & (r[7] ^ a[7]);
		case (op)
			3'h0: e.mem = m + 8'h01;
			3'h1: e.acc = m + 8'h01;
			default: ;
		endcase
		case (op)
			3'h0: e.sk = (e.mem == 8'h00);
			3'h1: e.sk = (e.acc == 8'h00);
			3'h2: e.sk = m[b];
			3'h3: e.sk = (m != 8'h00);
			default:
			begin
				if (op == 3'h4) e.acc = r;
				else e.mem = r;
				e.fl = {r == 8'h00, ov ^ r[7], ov, r == 8'h00, a[3:0] >= m[3:0], a >= m};
			end
		endcase
		return e;
	endfunction

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		logic [1:0]  r;
		logic [31:0] d;
		logic [2:0]  op, b;
		logic [3:0]  ix;
		logic [7:0]  a, m, ma;
		logic [5:0]  f;
		sktd_exp_t   e;
		int          sk;
		{aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
		wstrb = 4'hF;
		sk = 0;
		void'($urandom(32'h3343));
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rd(8'h10, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		wr(8'h20, 32'h5A, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		// first twelve walk every op twice; every third operand is all ones
		for (int i = 0; i < 48; i++)
		begin
			op = (i < 12) ? 3'(i / 2) : 3'($urandom % 6);
			b = 3'($urandom);
			ix = 4'($urandom);
			a = 8'($urandom);
			f = 6'($urandom);
			m = (i % 3 == 0) ? 8'hFF : (i % 3 == 1) ? 8'h00 : 8'($urandom);
			ma = {MEM_PAGE, ix, 2'h0};
			wr(ADDR_ACC, {24'h0, a}, r);
			wr(ma, {24'h0, m}, r);
			wr(ADDR_STAT, {26'h0, f}, r);
			wr(ADDR_CMD, {20'h0, ix, 1'h0, b, 1'h0, op}, r);
			chk({30'h0, r}, {30'h0, RESP_OKAY});
			do rd(ADDR_STAT, d, r);
			while (d[STAT_BUSY] !== 1'h0);
			e = model(op, b, a, m, f);
			sk += e.sk;
			rd(ADDR_ACC, d, r);
			chk(d, {24'h0, e.acc});
			chk({30'h0, r}, {30'h0, RESP_OKAY});
			rd(ma, d, r);
			chk(d, {24'h0, e.mem});
			rd(ADDR_STAT, d, r);
			chk(d, {22'h0, e.sk, 3'h0, e.fl});
			chk(n_dummy, sk);
		end
		// refused writes: unknown opcode, masked byte lane, read-only counter
		wr(ADDR_CMD, {20'h0, ix, 8'h07}, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		wstrb <= 4'h0;
		wr(ADDR_ACC, {24'h0, ~e.acc}, r);
		wstrb <= 4'hF;
		wr(ADDR_SKCNT, 32'hFF, r);
		rd(ADDR_CMD, d, r);
		chk(d, {20'h0, ix, 1'h0, b, 1'h0, op});
		rd(ADDR_ACC, d, r);
		chk(d, {24'h0, e.acc});
		rd(ADDR_STAT, d, r);
		chk(d, {22'h0, e.sk, 3'h0, e.fl});
		rd(ADDR_SKCNT, d, r);
		chk(d, {24'h0, 8'(sk)});
		test_done;
	end

	initial
	begin
		repeat (30000) @(posedge aclk);
		errors++;
		test_done;
	end
endmodule

`default_nettype wire
